/* verilog/mfc_pkg.sv */
`default_nettype none
package mfc_pkg;

    // timing, in nanoseconds as specified, then in mclk cycles
    localparam int CLK_PERIOD_NS = 25;
    localparam int CELL_NS       = 2000;
    localparam int WINDOW_NS     = 1000;
    localparam int PULSE_NS      = 250;
    localparam int CELL_CYC      = CELL_NS / CLK_PERIOD_NS;
    localparam int WINDOW_CYC    = WINDOW_NS / CLK_PERIOD_NS;
    localparam int PULSE_CYC     = (PULSE_NS / CLK_PERIOD_NS < 1) ? 1 : PULSE_NS / CLK_PERIOD_NS;
    localparam int CNT_W         = 7;

    // byte layout on the serial line
    localparam int       BYTE_CELLS = 8;
    localparam logic [2:0] LAST_CELL = 3'h7;
    localparam logic [2:0] MARK_CELL = 3'h2;
    localparam int       MARK_BIT   = BYTE_CELLS - 1 - int'(MARK_CELL);
    localparam logic [7:0] FILL_BYTE = 8'h00;

    // address mark data patterns (arbitrary values): cell 1 data must be one and
    // cell 2 data zero, otherwise the cell 2 clock is an ordinary inserted clock
    // and the reader cannot tell the mark from plain data
    localparam logic [7:0] MARK_INDEX   = 8'h4c;
    localparam logic [7:0] MARK_ID      = 8'h4e;
    localparam logic [7:0] MARK_DATA    = 8'h4b;
    localparam logic [7:0] MARK_DELETED = 8'h48;

    // crc
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_GOOD = 16'h0000;

    // writer sequencing, gray along idle -> data -> crc high -> crc low
    typedef enum logic [1:0] {
        W_IDLE   = 2'b00,
        W_DATA   = 2'b01,
        W_CRC_HI = 2'b11,
        W_CRC_LO = 2'b10
    } mfc_wstate_t;

    // one serial crc step, msb of the stream first
    function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic d);
        logic fb;
        fb = c[15] ^ d;
        return {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    endfunction

    // a whole byte, cell 0 first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = BYTE_CELLS - 1; i >= 0; i--) begin
            r = crc_bit(r, b[i]);
        end
        return r;
    endfunction

    function automatic logic is_mark(input logic [7:0] b);
        return (b == MARK_INDEX) || (b == MARK_ID) || (b == MARK_DATA) || (b == MARK_DELETED);
    endfunction

endpackage
`default_nettype wire

/* verilog/mfc_crc16.sv */
`timescale 1ns/1ps
`default_nettype none
module mfc_crc16
    import mfc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        init,
    input  wire logic [15:0] init_val,
    input  wire logic        shift,
    input  wire logic        din,
    output logic [15:0]      crc
);

    // init has priority so a field restart never mixes with the old remainder
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            crc <= CRC_INIT;
        end else if (init) begin
            crc <= init_val;
        end else if (shift) begin
            crc <= crc_bit(crc, din);
        end
    end

endmodule
`default_nettype wire

/* verilog/mfc_codec.sv */
`timescale 1ns/1ps
`default_nettype none
module mfc_codec
    import mfc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    // byte side, write path
    input  wire logic       wr_en,
    input  wire logic       wr_valid,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_mark,
    input  wire logic       wr_last,
    output logic            wr_ready,
    // serial write line to the drive
    output logic            wr_pulse,
    // serial read line from the drive
    input  wire logic       rd_en,
    input  wire logic       rd_pulse,
    // byte side, read path
    output logic            rd_sync,
    output logic            rd_strobe,
    output logic [7:0]      rd_byte,
    output logic            rd_mark,
    output logic            rd_crc_err
);

    ////////////////////////////////////////////////////////////////////////////////
    // write path

    mfc_wstate_t      wstate;
    logic [CNT_W-1:0] wr_cnt;
    logic [2:0]       wr_cell;
    logic [7:0]       wr_sr;
    logic             wr_cur_mark;
    logic             wr_cur_last;
    logic             hold_mark;
    logic             hold_last;
    logic [7:0]       hold_data;
    logic             prev_d;
    logic             prev_c;
    logic             cur_c;
    logic [CNT_W-1:0] pulse_cnt;
    logic [15:0]      wcrc;
    logic             cell_d;
    logic             cell_c;
    logic             wr_cell_end;
    logic             wr_boundary;
    logic             fire;

    // data of the cell on the line is always the top of the shifter
    assign cell_d = wr_sr[7];
    // extra clock in cell 2 of a mark is what keeps marks apart from data
    assign cell_c = !cell_d && ((!prev_d && !prev_c) ||
                                (wr_cur_mark && wr_cell == MARK_CELL));
    assign wr_cell_end = wr_cnt == CNT_W'(CELL_CYC - 1);
    assign wr_boundary = wr_cell_end && wr_cell == LAST_CELL;
    // pulse starts at opening of clock window or of data window
    assign fire = (wr_cnt == '0 && cell_c) ||
                  (wr_cnt == CNT_W'(WINDOW_CYC) && cell_d);

    // cell timer and position within the byte
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_cnt  <= '0;
            wr_cell <= '0;
        end else if (!wr_en) begin
            wr_cnt  <= '0;
            wr_cell <= '0;
        end else if (wr_cell_end) begin
            wr_cnt  <= '0;
            wr_cell <= wr_cell + 3'h1;
        end else begin
            wr_cnt <= wr_cnt + CNT_W'(1);
        end
    end

    // clock history for the insertion rule
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prev_d <= 1'b0;
            prev_c <= 1'b0;
            cur_c  <= 1'b0;
        end else if (!wr_en) begin
            prev_d <= 1'b0;
            prev_c <= 1'b0;
            cur_c  <= 1'b0;
        end else if (wr_cnt == '0) begin
            cur_c <= cell_c;
        end else if (wr_cell_end) begin
            prev_d <= cell_d;
            prev_c <= cur_c;
        end
    end

    // one holding byte; the controller sees back-pressure through wr_ready
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_ready  <= 1'b1;
            hold_data <= FILL_BYTE;
            hold_mark <= 1'b0;
            hold_last <= 1'b0;
        end else if (wr_ready && wr_valid) begin
            wr_ready  <= 1'b0;
            hold_data <= wr_data;
            hold_mark <= wr_mark;
            hold_last <= wr_last;
        end else if (wr_boundary && !wr_ready && wr_en &&
                     wstate != W_CRC_HI && !(wstate == W_DATA && wr_cur_last)) begin
            wr_ready <= 1'b1;
        end
    end

    // byte sequencing: field bytes, then crc high, then crc low
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wstate      <= W_IDLE;
            wr_sr       <= FILL_BYTE;
            wr_cur_mark <= 1'b0;
            wr_cur_last <= 1'b0;
        end else if (!wr_en) begin
            wstate      <= W_IDLE;
            wr_sr       <= FILL_BYTE;
            wr_cur_mark <= 1'b0;
            wr_cur_last <= 1'b0;
        end else if (wr_boundary) begin
            wr_cur_mark <= 1'b0;
            wr_cur_last <= 1'b0;
            if (wstate == W_DATA && wr_cur_last) begin
                wstate <= W_CRC_HI;
                wr_sr  <= wcrc[15:8];
            end else if (wstate == W_CRC_HI) begin
                wstate <= W_CRC_LO;
                wr_sr  <= wcrc[7:0];
            end else if (!wr_ready) begin
                wstate      <= W_DATA;
                wr_sr       <= hold_data;
                wr_cur_mark <= hold_mark;
                wr_cur_last <= hold_last;
            end else begin
                // underrun: pad with fill cells, the field is closed
                wstate <= W_IDLE;
                wr_sr  <= FILL_BYTE;
            end
        end else if (wr_cell_end) begin
            wr_sr <= {wr_sr[6:0], 1'b0};
        end
    end

    // crc restarts on a mark and eats each field cell as it goes out
    mfc_crc16 u_wcrc (
        .mclk     (mclk),
        .reset    (reset),
        .init     (wr_boundary && wr_en && !wr_ready && hold_mark &&
                   wstate != W_CRC_HI && !(wstate == W_DATA && wr_cur_last)),
        .init_val (CRC_INIT),
        .shift    (wr_en && wstate == W_DATA && wr_cnt == '0),
        .din      (cell_d),
        .crc      (wcrc)
    );

    // fixed width pulse on the write line
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pulse_cnt <= '0;
            wr_pulse  <= 1'b0;
        end else if (!wr_en) begin
            pulse_cnt <= '0;
            wr_pulse  <= 1'b0;
        end else if (fire) begin
            pulse_cnt <= CNT_W'(PULSE_CYC - 1);
            wr_pulse  <= 1'b1;
        end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - CNT_W'(1);
        end else begin
            wr_pulse <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    logic [CNT_W-1:0] rd_cnt;
    logic             cap_c;
    logic             cap_d;
    logic [7:0]       clk_sr;
    logic [7:0]       dat_sr;
    logic [2:0]       rd_cell;
    logic             pend;
    logic             pend_mark;
    logic [7:0]       rd_hold;
    logic [15:0]      rcrc;
    logic             rd_cell_end;
    logic [7:0]       next_dat;
    logic [7:0]       next_clk;
    logic             mark_hit;

    assign rd_cell_end = rd_cnt == CNT_W'(CELL_CYC - 1);
    // cell end lies in the data window, so a pulse there counts as data
    assign next_dat = {dat_sr[6:0], cap_d | rd_pulse};
    assign next_clk = {clk_sr[6:0], cap_c};
    // clock in cell 2 where the insertion rule forbids it marks a byte start
    assign mark_hit = rd_cell_end && next_clk[MARK_BIT] && !next_dat[MARK_BIT] &&
                      (next_dat[MARK_BIT+1] || next_clk[MARK_BIT+1]) &&
                      is_mark(next_dat);

    // free running cell timer; no phase tracking, drift must stay inside a window
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_cnt <= '0;
        end else if (!rd_en || rd_cell_end) begin
            rd_cnt <= '0;
        end else begin
            rd_cnt <= rd_cnt + CNT_W'(1);
        end
    end

    // sort pulses into clock and data windows, gather both streams
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cap_c  <= 1'b0;
            cap_d  <= 1'b0;
            clk_sr <= '0;
            dat_sr <= '0;
        end else if (!rd_en) begin
            cap_c  <= 1'b0;
            cap_d  <= 1'b0;
            clk_sr <= '0;
            dat_sr <= '0;
        end else if (rd_cell_end) begin
            cap_c  <= 1'b0;
            cap_d  <= 1'b0;
            clk_sr <= next_clk;
            dat_sr <= next_dat;
        end else if (rd_pulse) begin
            if (rd_cnt < CNT_W'(WINDOW_CYC)) begin
                cap_c <= 1'b1;
            end else begin
                cap_d <= 1'b1;
            end
        end
    end

    // byte alignment; a fresh mark always realigns
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_sync   <= 1'b0;
            rd_cell   <= '0;
            pend      <= 1'b0;
            pend_mark <= 1'b0;
            rd_hold   <= '0;
        end else if (!rd_en) begin
            rd_sync   <= 1'b0;
            rd_cell   <= '0;
            pend      <= 1'b0;
            pend_mark <= 1'b0;
        end else if (mark_hit) begin
            rd_sync   <= 1'b1;
            rd_cell   <= '0;
            pend      <= 1'b1;
            pend_mark <= 1'b1;
            rd_hold   <= next_dat;
        end else if (rd_cell_end && rd_sync) begin
            rd_cell   <= rd_cell + 3'h1;
            pend      <= rd_cell == LAST_CELL;
            pend_mark <= 1'b0;
            rd_hold   <= next_dat;
        end else begin
            pend <= 1'b0;
        end
    end

    // mark already fully received, so seed the checker with the mark folded in
    mfc_crc16 u_rcrc (
        .mclk     (mclk),
        .reset    (reset),
        .init     (mark_hit),
        .init_val (crc_byte(CRC_INIT, next_dat)),
        .shift    (rd_cell_end && rd_sync && rd_en),
        .din      (next_dat[0]),
        .crc      (rcrc)
    );

    // delivery one cycle after the byte completes, once the remainder has settled
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_strobe  <= 1'b0;
            rd_byte    <= '0;
            rd_mark    <= 1'b0;
            rd_crc_err <= 1'b0;
        end else begin
            rd_strobe <= pend;
            if (pend) begin
                rd_byte    <= rd_hold;
                rd_mark    <= pend_mark;
                rd_crc_err <= rcrc != CRC_GOOD;
            end
        end
    end

endmodule
`default_nettype wire

/* bench/mfc_codec_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mfc_codec_properties
    import mfc_pkg::*;
(
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       wr_en,
    input wire logic       wr_valid,
    input wire logic       wr_last,
    input wire logic       wr_ready,
    input wire logic       wr_pulse,
    input wire logic       rd_en,
    input wire logic       rd_sync,
    input wire logic       rd_strobe,
    input wire logic [7:0] rd_byte,
    input wire logic       rd_mark,
    input wire logic       rd_crc_err
);
    logic [7:0] hi_cnt;
    logic [7:0] gap;
    logic [9:0] scnt;
    logic       prev_p;
    logic       run;
    logic       s_ok;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////////
    // write pulse length and spacing; gap saturates so long idles never look aligned
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hi_cnt <= 8'h00;
            gap    <= 8'h00;
            prev_p <= 1'b0;
            run    <= 1'b0;
        end else begin
            hi_cnt <= wr_pulse ? hi_cnt + 8'h01 : 8'h00;
            prev_p <= wr_pulse;
            gap    <= (wr_pulse && !prev_p) ? 8'h01 : (gap != 8'hff) ? gap + 8'h01 : gap;
            run    <= wr_en && (run || (wr_pulse && !prev_p));
        end
    end

    // distance between delivered bytes, only trusted while aligned
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            scnt <= 10'h000;
            s_ok <= 1'b0;
        end else begin
            scnt <= rd_strobe ? 10'h001 : (scnt != 10'h3ff) ? scnt + 10'h001 : scnt;
            s_ok <= rd_sync && (s_ok || rd_strobe);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_pulse_max: assert property (hi_cnt <= PULSE_CYC)
        else $error("write pulse too long");
    a_pulse_width: assert property (!wr_pulse && prev_p && wr_en |-> hi_cnt == PULSE_CYC)
        else $error("write pulse too short");
    a_pulse_grid: assert property (wr_pulse && !prev_p && run && gap != 8'hff
        |-> gap % WINDOW_CYC == 0 && gap >= WINDOW_CYC)
        else $error("flux pulse off the window grid");
    a_write_quiet: assert property (!wr_en ##1 !wr_en |-> !wr_pulse)
        else $error("flux while write gate low");
    a_ready_fall: assert property (wr_en && wr_valid && wr_ready |=> !wr_ready)
        else $error("ready stayed high after take");
    a_strobe_one: assert property (rd_strobe |=> !rd_strobe [*8])
        else $error("strobe too long");
    a_strobe_space: assert property (rd_strobe && !rd_mark && s_ok |-> scnt == 10'h280)
        else $error("byte strobe not eight cells apart");
    a_hold_byte: assert property (!rd_strobe |-> $stable(rd_byte) && $stable(rd_mark)
        && $stable(rd_crc_err))
        else $error("read outputs moved without strobe");
    a_mark_sync: assert property (rd_strobe && rd_mark |-> rd_sync)
        else $error("mark delivered without sync");
    a_gate_read: assert property (!rd_en |=> !rd_sync)
        else $error("sync kept with read gate low");

    c_mark: cover property (rd_strobe && rd_mark);
    c_err: cover property (rd_strobe && rd_crc_err);
    c_last: cover property (wr_valid && wr_ready && wr_last);
endmodule

bind mfc_codec mfc_codec_properties u_mfc_codec_properties (
    .mclk(mclk), .reset(reset), .wr_en(wr_en), .wr_valid(wr_valid), .wr_last(wr_last),
    .wr_ready(wr_ready), .wr_pulse(wr_pulse), .rd_en(rd_en), .rd_sync(rd_sync),
    .rd_strobe(rd_strobe), .rd_byte(rd_byte), .rd_mark(rd_mark), .rd_crc_err(rd_crc_err));
`default_nettype wire

/* bench/mfc_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mfc_drive_model (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic wr_pulse,
    input  wire logic flip,
    output logic      rd_pulse
);
    // head plays written flux straight back; flip adds a stray pulse to spoil a field
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_pulse <= 1'b0;
        end else begin
            rd_pulse <= wr_pulse | flip;
        end
    end
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mfc_pkg::*;
    typedef struct packed {logic cb; logic [7:0] b; logic m; logic ce; logic e;} mfc_exp_t;
    localparam logic [7:0] MARKS [4] = '{MARK_INDEX, MARK_ID, MARK_DATA, MARK_DELETED};
    logic       mclk, reset, wr_en, wr_valid, wr_mark, wr_last, wr_ready, wr_pulse;
    logic       rd_en, rd_pulse, rd_sync, rd_strobe, rd_mark, rd_crc_err, flip;
    logic [7:0] wr_data, rd_byte;
    logic [31:0] seed;
    mfc_exp_t   q[$];
    mfc_exp_t   e;
    int         n_mismatch, total_checks;

    mfc_codec u_mfc_codec (.mclk(mclk), .reset(reset), .wr_en(wr_en), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_mark(wr_mark), .wr_last(wr_last), .wr_ready(wr_ready),
        .wr_pulse(wr_pulse), .rd_en(rd_en), .rd_pulse(rd_pulse), .rd_sync(rd_sync),
        .rd_strobe(rd_strobe), .rd_byte(rd_byte), .rd_mark(rd_mark), .rd_crc_err(rd_crc_err));
    mfc_drive_model u_mfc_drive_model (.mclk(mclk), .reset(reset), .wr_pulse(wr_pulse),
        .flip(flip), .rd_pulse(rd_pulse));

    always #12.5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // bitwise crc kept apart from the design's own helpers
    function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0);
        return c;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // valid stays up between bytes so it is never toggled within one step
    task automatic send(input logic [7:0] b, input logic m, input logic l);
        int   n;
        logic ok;
        n = 0;
        wr_valid = 1'b1;
        wr_data = b;
        wr_mark = m;
        wr_last = l;
        do begin
            @(posedge mclk);
            ok = (wr_ready === 1'b1);
            #2;
            n++;
        end while (!ok && n < 2000);
        if (!ok) n_mismatch++;
    endtask

    // one field: mark, four bytes, crc; bad spoils a data cell on the way back
    task automatic field(input logic [7:0] mk, input logic bad, input int k);
        logic [15:0] c;
        logic [7:0]  b;
        int          n;
        c = crc8(CRC_INIT, mk);
        q.push_back({1'b1, mk, 1'b1, 2'b00});
        wr_en = 1'b1;
        rd_en = 1'b1;
        if (bad) fork
            begin
                repeat (2375) @(posedge mclk);
                #2;
                flip = 1'b1;
                repeat (10) @(posedge mclk);
                #2;
                flip = 1'b0;
            end
        join_none
        send(mk, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            b = bad ? 8'h00 : seed[7:0];
            c = crc8(c, b);
            q.push_back({!bad, b, 3'b000});
            send(b, 1'b0, i == 3);
        end
        q.push_back({!bad, c[15:8], 3'b000});
        q.push_back({!bad, c[7:0], 1'b0, 1'b1, bad});
        wr_valid = 1'b0;
        n = 0;
        while (q.size() != 0 && n < 8000) begin
            @(posedge mclk);
            #2;
            n++;
        end
        check(16'(q.size()), 16'h0);
        q.delete();
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (20) @(posedge mclk);
        #2;
        $display("test field %0d done", k);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scoreboard: strobes past the field (underrun fill) find an empty queue and pass
    always @(posedge mclk) begin
        if (rd_strobe === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            if (e.cb) check({8'h00, rd_byte}, {8'h00, e.b});
            check({15'h0, rd_mark}, {15'h0, e.m});
            if (e.ce) check({15'h0, rd_crc_err}, {15'h0, e.e});
        end
    end

    initial begin
        repeat (60000) @(posedge mclk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        {wr_en, wr_valid, wr_mark, wr_last, rd_en, flip} = 6'h00;
        wr_data = 8'h00;
        seed = 32'h0c0d1f8f;
        n_mismatch = 0;
        total_checks = 0;
        repeat (4) @(posedge mclk);
        #2;
        reset = 1'b0;
        for (int k = 0; k < 5; k++) field(MARKS[k % 4], k == 4, k);
        complete_run();
    end
endmodule
`default_nettype wire
